// [bench/lfs_power_stage_model.sv]
`timescale 1ns/1ps
// far side: switching timebase and the host's pulled-up fault line
module lfs_power_stage_model #(
  parameter int TICK_DIV = 2
) (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic faultFlagNOut,
  input  wire logic faultFlagNOe,
  output logic      swTick,
  output wire       faultFlagN
);
  int divCnt;

  // pull-up wins whenever the open drain is released
  assign faultFlagN = faultFlagNOe ? faultFlagNOut : 1'b1;

  // one pulse per switching period; a short period keeps skip runs brief
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      divCnt <= 0;
      swTick <= 1'b0;
    end else begin
      divCnt <= (divCnt == TICK_DIV - 1) ? 0 : divCnt + 1;
      swTick <= (divCnt == TICK_DIV - 1);
    end
  end
endmodule : lfs_power_stage_model

// [bench/test_led_driver_fault_supervisor.sv]
`timescale 1ns/1ps
module test_led_driver_fault_supervisor;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        topoBoost = 1'b1;
  logic        ovSense = 1'b0;
  logic        ovBelowHyst = 1'b1;
  logic        ocSense = 1'b0;
  logic        tempAboveSet = 1'b0;
  logic        tempBelowClr = 1'b1;
  logic [10:0] dimLevel = 11'h7FF;
  logic        gateEnable, dimSwitchDrive, faultFlagNOut, faultFlagNOe;
  logic        compReset, swTick;
  logic [9:0]  senseScale;
  wire         faultFlagN;
  int          nFail = 0;
  int          samplesChecked = 0;

  always #4 clk = ~clk;

  lfs_supervisor uut (
    .clk(clk), .rstn(rstn), .swTick(swTick), .topoBoost(topoBoost),
    .overvoltageSense(ovSense), .ovBelowHyst(ovBelowHyst),
    .overcurrentSense(ocSense), .tempAboveSet(tempAboveSet),
    .tempBelowClr(tempBelowClr), .pwmEnable(1'b1),
    .analogDimLevel(dimLevel), .gateEnable(gateEnable),
    .dimSwitchDrive(dimSwitchDrive), .faultFlagNOut(faultFlagNOut),
    .faultFlagNOe(faultFlagNOe), .compReset(compReset),
    .senseScale(senseScale));

  lfs_power_stage_model #(.TICK_DIV(2)) stage (
    .clk(clk), .rstn(rstn), .faultFlagNOut(faultFlagNOut),
    .faultFlagNOe(faultFlagNOe), .swTick(swTick),
    .faultFlagN(faultFlagN));

  task automatic wrap_up();
    $display("checks=%0d failures=%0d", samplesChecked, nFail);
    if (nFail == 0 && samplesChecked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      nFail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // look at outputs mid-cycle, away from the launching edge
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : settle

  // gate, dim switch and resolved fault line together
  task automatic outs(input logic [2:0] exp);
    chk({13'h0000, gateEnable, dimSwitchDrive, faultFlagN}, {13'h0000, exp});
  endtask : outs

  // bounded wait for the dim switch; a hang ends the run
  task automatic wait_dim(input logic v, input int lim, output int n);
    n = 0;
    while (dimSwitchDrive !== v) begin
      if (n >= lim) begin
        nFail++;
        wrap_up();
      end
      @(negedge clk);
      n++;
    end
  endtask : wait_dim

  task automatic ovp_test();
    @(posedge clk) begin ovSense <= 1'b1; ovBelowHyst <= 1'b0; end
    settle(4);
    outs(3'h0);
    @(posedge clk) ovSense <= 1'b0;
    settle(8);
    outs(3'h0);
    @(posedge clk) ovBelowHyst <= 1'b1;
    settle(4);
    outs(3'h7);
  endtask : ovp_test

  task automatic thermal_test();
    @(posedge clk) begin tempAboveSet <= 1'b1; tempBelowClr <= 1'b0; end
    settle(4);
    outs(3'h0);
    @(posedge clk) tempAboveSet <= 1'b0;
    settle(8);
    outs(3'h0);
    @(posedge clk) tempBelowClr <= 1'b1;
    settle(4);
    outs(3'h7);
  endtask : thermal_test

  // short held through one skip, repeats, then clears mid-skip
  task automatic hiccup_test();
    int n;
    int q = 2 * lfs_pkg::SHORT_DLY_SW;
    @(posedge clk) ocSense <= 1'b1;
    wait_dim(1'b0, 20, n);
    // tick every second clock, plus sync and output register latency
    chk(16'(n >= q + 3 && n <= q + 4), 16'h0001);
    outs(3'h0);
    chk({15'h0000, compReset}, 16'h0001);
    wait_dim(1'b1, 33000, n);
    chk(16'(n == 2 * lfs_pkg::SKIP_SW + 1), 16'h0001);
    wait_dim(1'b0, 12, n);
    chk(16'(n >= 2), 16'h0001);
    @(posedge clk) ocSense <= 1'b0;
    wait_dim(1'b1, 33000, n);
    settle(100);
    outs(3'h7);
  endtask : hiccup_test

  task automatic topo_test();
    @(posedge clk) begin topoBoost <= 1'b0; ocSense <= 1'b1; end
    settle(200);
    outs(3'h7);
    @(posedge clk) begin topoBoost <= 1'b1; ocSense <= 1'b0; end
    settle(6);
  endtask : topo_test

  task automatic dim_test();
    int lv[5] = '{99, 100, 600, 1099, 1500};
    int sc;
    logic g;
    foreach (lv[i]) begin
      g = (lv[i] > lfs_pkg::DIM_LO_MV); // zero threshold keeps gate off
      sc = !g ? 0 : (lv[i] > lfs_pkg::DIM_HI_MV) ? lfs_pkg::DIM_SPAN_MV
                                                 : lv[i] - lfs_pkg::DIM_LO_MV;
      @(posedge clk) dimLevel <= 11'(lv[i]);
      settle(3);
      chk({5'h00, g, senseScale}, {5'h00, g, 10'(sc)});
      chk({15'h0000, gateEnable}, {15'h0000, g});
    end
    @(posedge clk) dimLevel <= 11'h7FF;
    settle(3);
  endtask : dim_test

  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    settle(6);
    outs(3'h7);
    ovp_test();
    thermal_test();
    dim_test();
    topo_test();
    hiccup_test();
    wrap_up();
  end
endmodule : test_led_driver_fault_supervisor

// [verilog/lfs_pkg.sv]
package lfs_pkg;
  // clock and switching timebase
  localparam int    CLK_FREQ_HZ      = 125_000_000;
  // short must persist this many switching cycles before it counts
  localparam int    SHORT_DLY_SW     = 2;
  // skip interval in switching cycles before a restart attempt
  localparam int    SKIP_SW          = 16_000;
  localparam int    CNT_W            = 15;
  localparam logic [CNT_W-1:0] CNT_ZERO = 15'h0000;
  // thermal thresholds in degrees, encoded by the comparator inputs
  localparam int    TSD_SET_DEGC     = 165;
  localparam int    TSD_CLR_DEGC     = 145;
  // dimming thresholds in millivolts and span, for scale encoding
  localparam int    DIM_LO_MV        = 100;
  localparam int    DIM_HI_MV        = 1100;
  localparam int    DIM_SPAN_MV      = 1000;
  localparam int    LVL_W            = 11;
  localparam int    SCALE_W          = 10;
  localparam logic [SCALE_W-1:0] SCALE_FULL = 10'h3E8;
  localparam logic [SCALE_W-1:0] SCALE_ZERO = 10'h000;
  // configuration select
  localparam logic  TOPO_BOOST       = 1'b1;

  typedef enum logic [1:0] {
    LFS_RUN   = 2'b00,
    LFS_QUAL  = 2'b01,
    LFS_SKIP  = 2'b10
  } lfs_hic_t;
endpackage : lfs_pkg

// [verilog/lfs_supervisor.sv]
`timescale 1ns/1ps
// Summary of operation
// - an over-voltage trip forces gate, dim switch and fault flag low.
// - they stay low until output falls below threshold less hysteresis.
// - boost over-current for 2 switch cycles is a short; hiccup begins.
// - the dim switch is held low for the whole skip interval.
// - after the skip a restart is tried; a short seen again repeats it.
// - if the short is gone at restart, normal regulation resumes.
// - hiccup runs only in boost; other topologies keep regulating.
// - die above 165 C puts the device in standby with the fault flag low.
// - after thermal shutdown no restart until the die is below 145 C.
// - a dimming level above 1.1V gives full-scale sense threshold.
// - a dimming level below 0.1V turns the output off.
// - in between, the threshold scales by level minus 0.1 over a 1V span.
// - each short detection also forces gate low and clears compensation.
// - the skip interval lasts 16,000 switching cycles.
module lfs_supervisor (
  input  wire logic               clk,
  input  wire logic               rstn,
  input  wire logic               swTick,
  input  wire logic               topoBoost,
  input  wire logic               overvoltageSense,
  input  wire logic               ovBelowHyst,
  input  wire logic               overcurrentSense,
  input  wire logic               tempAboveSet,
  input  wire logic               tempBelowClr,
  input  wire logic               pwmEnable,
  input  wire logic [10:0]        analogDimLevel,
  output logic                    gateEnable,
  output logic                    dimSwitchDrive,
  output logic                    faultFlagNOut,
  output logic                    faultFlagNOe,
  output logic                    compReset,
  output logic [9:0]              senseScale
);
  logic        rstnMeta_q;
  logic        rstnSync_q;
  logic [4:0]  syncIn;
  logic [4:0]  syncOut;
  logic        ovS;
  logic        ovHystS;
  logic        ocS;
  logic        tHotS;
  logic        tCoolS;
  logic        ovFault_q;
  logic        ovFault_d;
  logic        tsdFault_q;
  logic        tsdFault_d;
  lfs_pkg::lfs_hic_t hic_q;
  lfs_pkg::lfs_hic_t hic_d;
  logic [lfs_pkg::CNT_W-1:0] cnt_q;
  logic [lfs_pkg::CNT_W-1:0] cnt_d;
  logic        shortHit;
  logic        gate_d;
  logic        dim_d;
  logic        flagOe_d;
  logic        comp_d;
  logic [9:0]  scale_d;
  logic        asrtOn_q; // checks start once registers leave reset
  logic        asrtOn_d;

  // scale of full-scale threshold in thousandths from level in mV
  function automatic logic [9:0] dimScale(input logic [10:0] lvl);
    logic [10:0] off;
    off = 11'h000;
    if (lvl > 11'(lfs_pkg::DIM_HI_MV)) begin
      dimScale = lfs_pkg::SCALE_FULL;
    end else if (lvl < 11'(lfs_pkg::DIM_LO_MV)) begin
      dimScale = lfs_pkg::SCALE_ZERO;
    end else begin
      off = lvl - 11'(lfs_pkg::DIM_LO_MV);
      dimScale = off[9:0];
    end
  endfunction : dimScale

  // reset release through two flops; async assert, constant only
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rstnMeta_q <= 1'b0;
      rstnSync_q <= 1'b0;
    end else begin
      rstnMeta_q <= 1'b1;
      rstnSync_q <= rstnMeta_q;
    end
  end

  assign syncIn = {tempBelowClr, tempAboveSet, overcurrentSense,
                   ovBelowHyst, overvoltageSense};

  // comparators are asynchronous to the timebase
  lfs_sync #(.W(5)) uSync (
    .clk  (clk),
    .rstn (rstnSync_q),
    .din  (syncIn),
    .dout (syncOut)
  );

  assign ovS     = syncOut[0];
  assign ovHystS = syncOut[1];
  assign ocS     = syncOut[2];
  assign tHotS   = syncOut[3];
  assign tCoolS  = syncOut[4];

  // latched faults: set wins over the release condition
  always_comb begin
    ovFault_d  = ovFault_q;
    tsdFault_d = tsdFault_q;
    if (ovS) begin
      ovFault_d = 1'b1;
    end else if (ovFault_q && ovHystS) begin
      ovFault_d = 1'b0;
    end
    if (tHotS) begin
      tsdFault_d = 1'b1;
    end else if (tsdFault_q && tCoolS) begin
      tsdFault_d = 1'b0;
    end
  end

  // hiccup machine; one counter for qualify delay and skip
  always_comb begin
    hic_d    = hic_q;
    cnt_d    = cnt_q;
    shortHit = 1'b0;
    case (hic_q)
      lfs_pkg::LFS_RUN: begin
        if (topoBoost == lfs_pkg::TOPO_BOOST && ocS) begin
          hic_d = lfs_pkg::LFS_QUAL;
          cnt_d = lfs_pkg::CNT_ZERO;
        end
      end
      lfs_pkg::LFS_QUAL: begin
        if (!ocS || topoBoost != lfs_pkg::TOPO_BOOST) begin
          hic_d = lfs_pkg::LFS_RUN;
        end else if (swTick) begin
          if (cnt_q == lfs_pkg::CNT_W'(lfs_pkg::SHORT_DLY_SW - 1)) begin
            hic_d    = lfs_pkg::LFS_SKIP;
            cnt_d    = lfs_pkg::CNT_ZERO;
            shortHit = 1'b1;
          end else begin
            cnt_d = cnt_q + 1'b1;
          end
        end
      end
      lfs_pkg::LFS_SKIP: begin
        if (swTick) begin
          if (cnt_q == lfs_pkg::CNT_W'(lfs_pkg::SKIP_SW - 1)) begin
            hic_d = lfs_pkg::LFS_RUN;
            cnt_d = lfs_pkg::CNT_ZERO;
          end else begin
            cnt_d = cnt_q + 1'b1;
          end
        end
      end
      default: begin
        hic_d = lfs_pkg::LFS_RUN;
        cnt_d = lfs_pkg::CNT_ZERO;
      end
    endcase
  end

  // outputs; every fault path forces gate low
  always_comb begin
    gate_d   = pwmEnable;
    dim_d    = pwmEnable;
    flagOe_d = 1'b0;
    comp_d   = 1'b0;
    asrtOn_d = 1'b1;
    scale_d  = dimScale(analogDimLevel);
    if (scale_d == lfs_pkg::SCALE_ZERO) begin
      gate_d = 1'b0;
    end
    if (hic_q == lfs_pkg::LFS_SKIP || shortHit) begin
      gate_d   = 1'b0;
      dim_d    = 1'b0;
      flagOe_d = 1'b1;
      comp_d   = 1'b1;
    end
    if (ovS || ovFault_q) begin
      gate_d   = 1'b0;
      dim_d    = 1'b0;
      flagOe_d = 1'b1;
      comp_d   = 1'b1;
    end
    if (tHotS || tsdFault_q) begin
      gate_d   = 1'b0;
      dim_d    = 1'b0; // standby keeps the string off too
      flagOe_d = 1'b1;
      comp_d   = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstnSync_q) begin
    if (!rstnSync_q) begin
      ovFault_q      <= 1'b0;
      tsdFault_q     <= 1'b0;
      hic_q          <= lfs_pkg::LFS_RUN;
      cnt_q          <= lfs_pkg::CNT_ZERO;
      gateEnable     <= 1'b0;
      dimSwitchDrive <= 1'b0;
      faultFlagNOe   <= 1'b0;
      faultFlagNOut  <= 1'b0;
      compReset      <= 1'b1;
      senseScale     <= lfs_pkg::SCALE_ZERO;
      asrtOn_q       <= 1'b0;
    end else begin
      ovFault_q      <= ovFault_d;
      tsdFault_q     <= tsdFault_d;
      hic_q          <= hic_d;
      cnt_q          <= cnt_d;
      gateEnable     <= gate_d;
      dimSwitchDrive <= dim_d;
      faultFlagNOe   <= flagOe_d;
      faultFlagNOut  <= 1'b0;
      compReset      <= comp_d;
      senseScale     <= scale_d;
      asrtOn_q       <= asrtOn_d;
    end
  end

  // over-voltage seen by sync stage forces gate low next edge
  property p_ovGate;
    @(posedge clk) disable iff (!asrtOn_q)
      ovS |=> !gateEnable && !dimSwitchDrive && faultFlagNOe;
  endproperty
  a_ovGate: assert property (p_ovGate)
    else $error("gate not forced low on over-voltage");

  property p_ovHold;
    @(posedge clk) disable iff (!asrtOn_q)
      ovFault_q && !ovHystS |=> ovFault_q;
  endproperty
  a_ovHold: assert property (p_ovHold)
    else $error("over-voltage latch released early");

  sequence s_qualDone;
    hic_q == lfs_pkg::LFS_QUAL && swTick && ocS &&
      cnt_q == lfs_pkg::CNT_W'(lfs_pkg::SHORT_DLY_SW - 1);
  endsequence
  property p_shortStart;
    @(posedge clk) disable iff (!asrtOn_q)
      s_qualDone ##1 1'b1 |-> hic_q == lfs_pkg::LFS_SKIP &&
        cnt_q == lfs_pkg::CNT_ZERO && !dimSwitchDrive && compReset;
  endproperty
  a_shortStart: assert property (p_shortStart)
    else $error("short not declared after qualify delay");

  property p_skipDim;
    @(posedge clk) disable iff (!asrtOn_q)
      hic_q == lfs_pkg::LFS_SKIP |=> !dimSwitchDrive && !gateEnable;
  endproperty
  a_skipDim: assert property (p_skipDim)
    else $error("dim switch on during skip");

  property p_skipEnd;
    @(posedge clk) disable iff (!asrtOn_q)
      hic_q == lfs_pkg::LFS_SKIP && swTick &&
        cnt_q == lfs_pkg::CNT_W'(lfs_pkg::SKIP_SW - 1)
        |=> hic_q == lfs_pkg::LFS_RUN;
  endproperty
  a_skipEnd: assert property (p_skipEnd)
    else $error("skip interval length wrong");

  property p_noBoostNoHic;
    @(posedge clk) disable iff (!asrtOn_q)
      topoBoost != lfs_pkg::TOPO_BOOST && hic_q == lfs_pkg::LFS_RUN
        |=> hic_q == lfs_pkg::LFS_RUN;
  endproperty
  a_noBoostNoHic: assert property (p_noBoostNoHic)
    else $error("hiccup entered outside boost");

  property p_tsdHold;
    @(posedge clk) disable iff (!asrtOn_q)
      tsdFault_q && !tCoolS |=> tsdFault_q && faultFlagNOe && !gateEnable;
  endproperty
  a_tsdHold: assert property (p_tsdHold)
    else $error("thermal standby released early");

  property p_dimOff;
    @(posedge clk) disable iff (!asrtOn_q)
      analogDimLevel < 11'(lfs_pkg::DIM_LO_MV) |=>
        !gateEnable && senseScale == lfs_pkg::SCALE_ZERO;
  endproperty
  a_dimOff: assert property (p_dimOff)
    else $error("output not off below low dim limit");

  property p_dimFull;
    @(posedge clk) disable iff (!asrtOn_q)
      analogDimLevel > 11'(lfs_pkg::DIM_HI_MV) |=>
        senseScale == lfs_pkg::SCALE_FULL;
  endproperty
  a_dimFull: assert property (p_dimFull)
    else $error("full scale not applied above high dim limit");
endmodule : lfs_supervisor

// [verilog/lfs_sync.sv]
`timescale 1ns/1ps
// two-flop level synchroniser, vector wide
module lfs_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] dout_d;

  // first stage feeds only the second
  always_comb begin
    meta_d = din;
    dout_d = meta_q;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_q <= '0;
      dout   <= '0;
    end else begin
      meta_q <= meta_d;
      dout   <= dout_d;
    end
  end
endmodule : lfs_sync
